// >>> design/pmt_timer.sv
`timescale 1ns/10ps
module pmt_timer
    import pmt_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    input wire logic [PMT_AW-1:0] addr,
    input wire logic [7:0] wdata,
    input wire logic wr,
    input wire logic rd,
    output logic [7:0] rdata,
    output logic match_out,
    output logic pwm_time_base,
    output logic serial_shift_clk,
    output logic irq
);
    typedef struct packed {
        logic [7:0] count_value;
        logic [7:0] period_value;
        logic [6:0] timer_control;
        logic [1:0] instr_div;
        logic match_irq_flag;
        logic match_irq_enable;
        logic [7:0] rdata;
    } pmt_state_t;

    pmt_state_t s_r;
    pmt_state_t s_nxt;

    logic wr_count;
    logic wr_ctrl;
    logic scaler_clear;
    logic timer_on;
    logic instr_tick;
    logic pre_tick;
    logic post_tick;
    logic match;
    logic [1:0] prescale_select;
    logic [3:0] pre_term;

    ////////////////////////////////////////////////////////////////////////
    // Tick chain

    assign wr_count = wr && (addr == PMT_OFF_COUNT);
    assign wr_ctrl = wr && (addr == PMT_OFF_CTRL);
    assign scaler_clear = wr_count || wr_ctrl;
    assign timer_on = s_r.timer_control[PMT_ON_BIT];
    assign prescale_select = s_r.timer_control[PMT_PRE_LSB +: 2];
    // Instruction clock is a quarter of the block clock
    assign instr_tick = timer_on && (s_r.instr_div == PMT_INSTR_DIV_M1);

    always_comb begin
        case (prescale_select)
            PMT_PRE_CODE_1: pre_term = PMT_PRE_DIV1_M1;
            PMT_PRE_CODE_4: pre_term = PMT_PRE_DIV4_M1;
            default: pre_term = PMT_PRE_DIV16_M1;
        endcase
    end

    pmt_divider u_pre (
        .clk(clk),
        .rst(rst),
        .clear(scaler_clear),
        .in_tick(instr_tick),
        .terminal(pre_term),
        .tick_out(pre_tick)
    );

    // Comparator runs every cycle; gated by on so a stopped timer stays quiet
    assign match = timer_on && (s_r.count_value == s_r.period_value);
    assign match_out = match;
    assign pwm_time_base = match;
    assign serial_shift_clk = match;

    // Postscaler advances once per match cycle, not once per tick
    logic match_pulse;
    logic match_seen_r;
    always_ff @(posedge clk) begin
        if (rst) begin
            match_seen_r <= 1'b0;
        end else begin
            match_seen_r <= match && !scaler_clear;
        end
    end
    assign match_pulse = match && !match_seen_r;

    pmt_divider u_post (
        .clk(clk),
        .rst(rst),
        .clear(scaler_clear),
        .in_tick(match_pulse),
        .terminal(s_r.timer_control[PMT_POST_LSB +: 4]),
        .tick_out(post_tick)
    );

    ////////////////////////////////////////////////////////////////////////
    // Registers and bus

    always_comb begin
        s_nxt = s_r;
        if (timer_on) begin
            s_nxt.instr_div = s_r.instr_div + 2'h1;
        end
        // Match holds for the whole prescaled tick; the restart waits for the next tick
        if (match) begin
            if (pre_tick) begin
                s_nxt.count_value = PMT_COUNT_RST;
            end
        end else if (pre_tick) begin
            s_nxt.count_value = s_r.count_value + 8'h01;
        end
        if (wr) begin
            case (addr)
                PMT_OFF_COUNT: s_nxt.count_value = wdata;
                PMT_OFF_PERIOD: s_nxt.period_value = wdata;
                PMT_OFF_CTRL: s_nxt.timer_control = wdata[6:0];
                PMT_OFF_FLAG: begin
                    if (wdata[PMT_MATCH_BIT]) begin
                        s_nxt.match_irq_flag = 1'b0;
                    end
                end
                PMT_OFF_ENABLE: s_nxt.match_irq_enable = wdata[PMT_MATCH_BIT];
                default: begin
                end
            endcase
        end
        // Set beats a same-cycle clear so no event is lost
        if (post_tick) begin
            s_nxt.match_irq_flag = 1'b1;
        end
        s_nxt.rdata = 8'h00;
        if (rd) begin
            case (addr)
                PMT_OFF_COUNT: s_nxt.rdata = s_r.count_value;
                PMT_OFF_PERIOD: s_nxt.rdata = s_r.period_value;
                PMT_OFF_CTRL: s_nxt.rdata = {1'b0, s_r.timer_control};
                PMT_OFF_FLAG: s_nxt.rdata[PMT_MATCH_BIT] = s_r.match_irq_flag;
                PMT_OFF_ENABLE: s_nxt.rdata[PMT_MATCH_BIT] = s_r.match_irq_enable;
                default: s_nxt.rdata = 8'h00;
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            s_r <= '0;
            s_r.count_value <= PMT_COUNT_RST;
            s_r.period_value <= PMT_PERIOD_RST;
            s_r.timer_control <= PMT_CTRL_RST;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign rdata = s_r.rdata;
    assign irq = s_r.match_irq_flag && s_r.match_irq_enable;
endmodule

// >>> design/pmt_pkg.sv
package pmt_pkg;
    localparam int PMT_AW = 3;
    localparam logic [2:0] PMT_OFF_COUNT = 3'h0;
    localparam logic [2:0] PMT_OFF_PERIOD = 3'h1;
    localparam logic [2:0] PMT_OFF_CTRL = 3'h2;
    localparam logic [2:0] PMT_OFF_FLAG = 3'h3;
    localparam logic [2:0] PMT_OFF_ENABLE = 3'h4;
    localparam int PMT_PRE_LSB = 0;
    localparam int PMT_ON_BIT = 2;
    localparam int PMT_POST_LSB = 3;
    localparam int PMT_MATCH_BIT = 1;
    localparam logic [7:0] PMT_COUNT_RST = 8'h00;
    localparam logic [7:0] PMT_PERIOD_RST = 8'hff;
    localparam logic [6:0] PMT_CTRL_RST = 7'h00;
    localparam logic [1:0] PMT_INSTR_DIV_M1 = 2'h3;
    localparam logic [3:0] PMT_PRE_DIV1_M1 = 4'h0;
    localparam logic [3:0] PMT_PRE_DIV4_M1 = 4'h3;
    localparam logic [3:0] PMT_PRE_DIV16_M1 = 4'hf;
    localparam logic [1:0] PMT_PRE_CODE_1 = 2'h0;
    localparam logic [1:0] PMT_PRE_CODE_4 = 2'h1;
endpackage

// >>> design/pmt_divider.sv
`timescale 1ns/10ps
// Modulo counter: pulses tick_out on the in_tick that completes terminal+1 ticks
module pmt_divider
    import pmt_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    input wire logic clear,
    input wire logic in_tick,
    input wire logic [3:0] terminal,
    output logic tick_out
);
    typedef struct packed {
        logic [3:0] cnt;
    } pmt_div_state_t;

    pmt_div_state_t s_r;
    pmt_div_state_t s_nxt;

    always_comb begin
        s_nxt = s_r;
        tick_out = in_tick && (s_r.cnt >= terminal);
        if (clear) begin
            s_nxt.cnt = 4'h0;
        end else if (in_tick) begin
            s_nxt.cnt = tick_out ? 4'h0 : s_r.cnt + 4'h1;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end
endmodule

// >>> test/pmt_assertions.sv
`timescale 1ns/10ps
module pmt_checker
    import pmt_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    input wire logic [PMT_AW-1:0] addr,
    input wire logic [7:0] wdata,
    input wire logic wr,
    input wire logic rd,
    input wire logic [7:0] rdata,
    input wire logic match_out,
    input wire logic pwm_time_base,
    input wire logic serial_shift_clk,
    input wire logic irq
);
default clocking cb @(posedge clk); endclocking
default disable iff (rst);
sequence s_per_wr;
    wr && addr == PMT_OFF_PERIOD;
endsequence
sequence s_per_rd;
    rd && addr == PMT_OFF_PERIOD;
endsequence
////////////////////////////////////////////////////////////////////////////////
a_rdata_idle: assert property (!rd |=> rdata == 8'h00)
    else $error("read data not zero");
a_period_rw: assert property (s_per_wr ##1 s_per_rd |=> rdata == $past(wdata, 2))
    else $error("period readback");
a_ctrl_top: assert property (rd && addr == PMT_OFF_CTRL |=> !rdata[7])
    else $error("control bit 7 set");
a_pwm_same: assert property (pwm_time_base == match_out)
    else $error("pwm base differs");
a_shift_same: assert property (serial_shift_clk == match_out)
    else $error("shift clock differs");
a_match_hold: assert property ($rose(match_out) && !wr && !$past(wr) |=> match_out)
    else $error("match too short");
a_off_quiet: assert property (wr && addr == PMT_OFF_CTRL && !wdata[2] |=> !match_out)
    else $error("match while off");
a_irq_cause: assert property ($rose(irq) |-> $past(wr) || match_out || $past(match_out))
    else $error("irq without cause");
a_irq_sticky: assert property ($fell(irq) |-> $past(wr))
    else $error("irq dropped alone");
endmodule
bind pmt_timer pmt_checker pmt_checker_inst (.clk, .rst, .addr, .wdata, .wr, .rd, .rdata,
    .match_out, .pwm_time_base, .serial_shift_clk, .irq);

// >>> test/period_match_timer_test.sv
`timescale 1ns/10ps
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin n_mismatch++; \
    $display("unexpected at %0t: %h vs %h", $time, a, b); end end
module period_match_timer_test
    import pmt_pkg::*;
;
logic clk = 0, rst = 1, wr = 0, rd = 0, match_out, irq;
logic [2:0] addr = 3'h0;
logic [7:0] wdata = 8'h00, rdata;
int n_mismatch = 0, num_checks = 0, cyc = 0, gap;
// Rows: address, write data, expected readback
logic [18:0] rows[4] = '{{3'h1, 8'h5a, 8'h5a}, {3'h0, 8'h33, 8'h33},
    {3'h5, 8'hff, 8'h00}, {3'h2, 8'h83, 8'h03}};
int gaps[4] = '{12, 48, 192, 192};
pmt_timer pmt_timer_inst (.clk, .rst, .addr, .wdata, .wr, .rd, .rdata, .match_out,
    .pwm_time_base(), .serial_shift_clk(), .irq);
initial forever #20 clk = ~clk;
////////////////////////////////////////////////////////////////////////////////
task automatic wr_reg(input logic [2:0] a, input logic [7:0] d);
    @(posedge clk) begin addr <= a; wdata <= d; wr <= 1; end
    @(posedge clk) wr <= 0;
    #1;
endtask
task automatic rchk(input logic [2:0] a, input logic [7:0] e);
    @(posedge clk) begin addr <= a; rd <= 1; end
    @(posedge clk) rd <= 0;
    #1 `CHK(rdata, e)
endtask
// Counts falling edges up to the next first cycle of a match
task automatic rise;
    gap = 0;
    while (match_out === 1'b1 && gap < 400) begin @(negedge clk); gap++; end
    while (match_out !== 1'b1 && gap < 400) begin @(negedge clk); gap++; end
endtask
task automatic wrap_up;
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
endtask
always @(posedge clk) begin
    cyc++;
    if (cyc == 8000) begin n_mismatch++; wrap_up; end
end
////////////////////////////////////////////////////////////////////////////////
initial begin
    repeat (3) @(posedge clk);
    rst <= 0;
    rchk(3'h1, 8'hff);
    rchk(3'h0, 8'h00);
    rchk(3'h2, 8'h00);
    $display("test reset done");
    // Back-to-back write then read of the period, no idle cycle between
    @(posedge clk) begin addr <= 3'h1; wdata <= 8'h77; wr <= 1; end
    @(posedge clk) begin wr <= 0; rd <= 1; end
    @(posedge clk) rd <= 0;
    #1 `CHK(rdata, 8'h77)
    $display("test back to back done");
    foreach (rows[i]) begin
        wr_reg(rows[i][18:16], rows[i][15:8]);
        rchk(rows[i][18:16], rows[i][7:0]);
    end
    rchk(3'h0, 8'h33);
    $display("test registers done");
    wr_reg(3'h1, 8'h02);
    wr_reg(3'h0, 8'h00);
    for (int i = 0; i < 4; i++) begin
        wr_reg(3'h2, 8'h04 | 8'(i));
        rise;
        rise;
        `CHK(gap, gaps[i])
    end
    $display("test prescale done");
    wr_reg(3'h2, 8'h00);
    wr_reg(3'h3, 8'h02);
    wr_reg(3'h4, 8'h02);
    wr_reg(3'h0, 8'h00);
    wr_reg(3'h2, 8'h0c);
    rise;
    repeat (2) @(negedge clk);
    `CHK(irq, 1'b0)
    rise;
    repeat (2) @(negedge clk);
    `CHK(irq, 1'b1)
    wr_reg(3'h2, 8'h00);
    wr_reg(3'h4, 8'h00);
    `CHK(irq, 1'b0)
    wr_reg(3'h4, 8'h02);
    `CHK(irq, 1'b1)
    wr_reg(3'h3, 8'h02);
    `CHK(irq, 1'b0)
    $display("test interrupt done");
    wrap_up;
end
endmodule
